/* rtl/pmc_top.sv */
// register file and control logic of the media mode control block
//
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module pmc_top #(
    parameter int        NPORT   = 2,
    parameter logic [1:0] DS_DEF = 2'h1
) (
    // clock and reset
    input  wire logic                       core_clk_in,
    input  wire logic                       rst_in,
    // apb slave
    input  wire logic                       psel_in,
    input  wire logic                       penable_in,
    input  wire logic                       pwrite_in,
    input  wire logic [11:0]                paddr_in,
    input  wire logic [31:0]                pwdata_in,
    output logic                            pready_out,
    output logic                            pslverr_out,
    output logic [31:0]                     prdata_out,
    // board and line side
    input  wire logic [3:0]                 board_address_straps_in,
    input  wire pmc_pkg::pmc_line_s [NPORT-1:0] line_in,
    // resolved controls
    output pmc_pkg::pmc_ctl_s [NPORT-1:0]   ctl_out,
    output logic [1:0]                      mac_mode_out,
    output logic                            mac_quad_out
);
    logic [15:0] ctrl_reg   [NPORT];
    logic [15:0] xovcfg_reg [NPORT];
    logic [1:0]  manxov_reg [NPORT];
    logic [15:0] ext1_reg   [NPORT];
    logic        te_reg     [NPORT];
    logic        seran_reg  [NPORT];
    logic [1:0]  dsfail_reg [NPORT];
    logic        dsact_reg  [NPORT];
    pmc_pkg::pmc_rr_e rr_reg [NPORT];
    logic [1:0]  macmode_reg;
    logic [3:0]  straps_reg;
    logic        straps_ok_reg;
    logic [31:0] prdata_reg;
    logic        perr_reg;

    // all checks run on the core clock and pause in reset
    default clocking dcb @(posedge core_clk_in);
    endclocking
    default disable iff (rst_in);

    wire logic access = psel_in && penable_in;
    wire logic wr     = access && pwrite_in;

    // decode of a port register hit
    function automatic logic hit(input logic [11:0] a, input int p, input logic [11:0] off);
        hit = (a == (off + 12'(p) * pmc_pkg::PORT_STRIDE));
    endfunction : hit

    assign pready_out  = 1'b1;
    assign pslverr_out = perr_reg;
    assign prdata_out  = prdata_reg;

    // straps sampled once after reset release
    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            straps_reg    <= 4'h0;
            straps_ok_reg <= 1'b0;
        end
        else if (!straps_ok_reg)
        begin
            straps_reg    <= board_address_straps_in;
            straps_ok_reg <= 1'b1;
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
            macmode_reg <= pmc_pkg::MAC_SGMII;
        else if (wr && paddr_in == pmc_pkg::OFF_GLOBAL)
            macmode_reg <= pwdata_in[pmc_pkg::B_MACMODE +: 2];
    end

    assign mac_mode_out = macmode_reg;
    assign mac_quad_out = (macmode_reg == pmc_pkg::MAC_QSGMII);

    property p_mac_quad;
        (mac_mode_out == pmc_pkg::MAC_SGMII) |-> !mac_quad_out;
    endproperty
    a_mac_quad : assert property (p_mac_quad)
        else $error("sgmii mode shows quad");

    genvar g;
    generate
        for (g = 0; g < NPORT; g++)
        begin : g_port
            logic [4:0] base_addr;
            logic [4:0] addr_fwd;

            always_ff @(posedge core_clk_in or posedge rst_in)
            begin
                if (rst_in)
                begin
                    ctrl_reg[g]   <= pmc_pkg::CTRL_RST;
                    xovcfg_reg[g] <= pmc_pkg::XOVCFG_RST;
                    manxov_reg[g] <= pmc_pkg::MX_AUTO;
                    ext1_reg[g]   <= pmc_pkg::EXT1_RST;
                    te_reg[g]     <= 1'b0;
                    seran_reg[g]  <= pmc_pkg::SERAN_RST[pmc_pkg::B_SERAN];
                end
                else
                begin
                    if (ctrl_reg[g][pmc_pkg::B_SWRST])
                        ctrl_reg[g][pmc_pkg::B_SWRST] <= 1'b0;
                    if (wr && hit(paddr_in, g, pmc_pkg::OFF_CTRL))
                        ctrl_reg[g] <= pwdata_in[15:0];
                    if (wr && hit(paddr_in, g, pmc_pkg::OFF_XOVCFG))
                        xovcfg_reg[g] <= pwdata_in[15:0];
                    if (wr && hit(paddr_in, g, pmc_pkg::OFF_MANXOV))
                        manxov_reg[g] <= pwdata_in[3:2];
                    if (wr && hit(paddr_in, g, pmc_pkg::OFF_EXT1))
                        ext1_reg[g] <= pwdata_in[15:0];
                    if (wr && hit(paddr_in, g, pmc_pkg::OFF_EEE))
                        te_reg[g] <= pwdata_in[pmc_pkg::B_TE];
                    if (wr && hit(paddr_in, g, pmc_pkg::OFF_SERAN))
                        seran_reg[g] <= pwdata_in[pmc_pkg::B_SERAN];
                end
            end

            always_ff @(posedge core_clk_in or posedge rst_in)
            begin
                if (rst_in)
                begin
                    dsfail_reg[g] <= 2'h0;
                    dsact_reg[g]  <= 1'b0;
                end
                // gigabit partner leaves downshift without reset
                else if (line_in[g].gig_partner || !ext1_reg[g][pmc_pkg::B_DS_EN])
                begin
                    dsfail_reg[g] <= 2'h0;
                    dsact_reg[g]  <= 1'b0;
                end
                else if (line_in[g].gig_fail && !dsact_reg[g])
                begin
                    if (dsfail_reg[g] >= ext1_reg[g][pmc_pkg::B_DS_CNT +: 2])
                        dsact_reg[g] <= 1'b1;
                    else
                        dsfail_reg[g] <= dsfail_reg[g] + 2'h1;
                end
            end

            always_ff @(posedge core_clk_in or posedge rst_in)
            begin
                if (rst_in)
                    rr_reg[g] <= pmc_pkg::RR_LOCAL;
                else
                begin
                    unique case (rr_reg[g])
                        pmc_pkg::RR_LOCAL:
                            if (line_in[g].ring_req)
                                rr_reg[g] <= pmc_pkg::RR_WAIT;
                        pmc_pkg::RR_WAIT:
                            if (!line_in[g].ring_req)
                                rr_reg[g] <= pmc_pkg::RR_LOCAL;
                            else if (line_in[g].timing_lock)
                                rr_reg[g] <= pmc_pkg::RR_RECOVER;
                        pmc_pkg::RR_RECOVER:
                            if (!line_in[g].ring_req)
                                rr_reg[g] <= pmc_pkg::RR_LOCAL;
                        default:
                            rr_reg[g] <= pmc_pkg::RR_LOCAL;
                    endcase
                end
            end

            assign base_addr = {straps_reg, 1'b0} + 5'(g);
            assign addr_fwd  = ext1_reg[g][pmc_pkg::B_ADDR_REV] ?
                               {base_addr[0], base_addr[1], base_addr[2], base_addr[3], base_addr[4]} : base_addr;

            always_comb
            begin
                ctl_out[g].mgmt_addr = addr_fwd;
                ctl_out[g].unidir_tx = ctrl_reg[g][pmc_pkg::B_UNIDIR];
                ctl_out[g].fibre_tx_en = ctrl_reg[g][pmc_pkg::B_UNIDIR] || line_in[g].link_ok;
                ctl_out[g].ams_en = !ctrl_reg[g][pmc_pkg::B_UNIDIR];
                ctl_out[g].an_en = ctrl_reg[g][pmc_pkg::B_ANEN];
                if (!ctrl_reg[g][pmc_pkg::B_ANEN])
                    ctl_out[g].speed = {ctrl_reg[g][pmc_pkg::B_SPD_LSB], ctrl_reg[g][pmc_pkg::B_SPD_MSB]} ==
                                       2'h3 ? pmc_pkg::SPD_1000 :
                                       {ctrl_reg[g][pmc_pkg::B_SPD_LSB], ctrl_reg[g][pmc_pkg::B_SPD_MSB]};
                else if (!line_in[g].partner_an)
                    ctl_out[g].speed = line_in[g].pd_speed;
                else
                    ctl_out[g].speed = dsact_reg[g] ? pmc_pkg::SPD_100 : pmc_pkg::SPD_1000;
                ctl_out[g].full_duplex = ctrl_reg[g][pmc_pkg::B_ANEN] || ctrl_reg[g][pmc_pkg::B_DUPLEX];
                ctl_out[g].xov_auto = !xovcfg_reg[g][pmc_pkg::B_XOV_DIS] &&
                                      (ctrl_reg[g][pmc_pkg::B_ANEN] || !xovcfg_reg[g][pmc_pkg::B_XOV_FORCED]);
                ctl_out[g].pol_auto = !xovcfg_reg[g][pmc_pkg::B_POL_DIS];
                if (manxov_reg[g] == pmc_pkg::MX_MDI)
                    ctl_out[g].map = pmc_pkg::MAP_MDI;
                else if (manxov_reg[g] == pmc_pkg::MX_MDIX)
                    ctl_out[g].map = pmc_pkg::MAP_MDIX;
                else if (ctl_out[g].xov_auto)
                    ctl_out[g].map = line_in[g].xov_map;
                else
                    ctl_out[g].map = pmc_pkg::MAP_MDI;
                ctl_out[g].adv_gig = !dsact_reg[g];
                ctl_out[g].te_mode = te_reg[g];
                // lpi only at 100 and 1000
                ctl_out[g].lpi_allow = (ctl_out[g].speed == pmc_pkg::SPD_100) ||
                                       (ctl_out[g].speed == pmc_pkg::SPD_1000);
                ctl_out[g].tx_recovered = (rr_reg[g] == pmc_pkg::RR_RECOVER);
                ctl_out[g].soft_reset = ctrl_reg[g][pmc_pkg::B_SWRST];
            end

            // recovered clock used only with lock history
            property p_rr_hist;
                $rose(ctl_out[g].tx_recovered) |-> $past(line_in[g].timing_lock);
            endproperty
            a_rr_hist : assert property (p_rr_hist)
                else $error("recovered clock without lock");

            property p_rr_local;
                (rr_reg[g] == pmc_pkg::RR_LOCAL) |=> !ctl_out[g].tx_recovered;
            endproperty
            a_rr_local : assert property (p_rr_local)
                else $error("recovered clock straight from local");

            property p_unidir;
                ctrl_reg[g][pmc_pkg::B_UNIDIR] |-> ctl_out[g].fibre_tx_en && !ctl_out[g].ams_en;
            endproperty
            a_unidir : assert property (p_unidir)
                else $error("unidirectional tx gated");

            property p_swrst;
                ctrl_reg[g][pmc_pkg::B_SWRST] && !wr |=> !ctrl_reg[g][pmc_pkg::B_SWRST];
            endproperty
            a_swrst : assert property (p_swrst)
                else $error("soft reset stuck");

            property p_manx;
                manxov_reg[g] == pmc_pkg::MX_MDIX |-> ctl_out[g].map == pmc_pkg::MAP_MDIX;
            endproperty
            a_manx : assert property (p_manx)
                else $error("manual crossover ignored");

            property p_mdi;
                manxov_reg[g] == pmc_pkg::MX_MDI |-> ctl_out[g].map == pmc_pkg::MAP_MDI;
            endproperty
            a_mdi : assert property (p_mdi)
                else $error("manual straight wiring ignored");

            property p_ds;
                line_in[g].gig_partner |=> !dsact_reg[g] && ctl_out[g].adv_gig;
            endproperty
            a_ds : assert property (p_ds)
                else $error("downshift not left");

            property p_ds_spd;
                dsact_reg[g] && ctrl_reg[g][pmc_pkg::B_ANEN] && line_in[g].partner_an |->
                    ctl_out[g].speed == pmc_pkg::SPD_100;
            endproperty
            a_ds_spd : assert property (p_ds_spd)
                else $error("downshift keeps gigabit speed");

            property p_pd;
                ctrl_reg[g][pmc_pkg::B_ANEN] && !line_in[g].partner_an |-> ctl_out[g].speed == line_in[g].pd_speed;
            endproperty
            a_pd : assert property (p_pd)
                else $error("parallel detect speed ignored");

            property p_forced;
                !ctrl_reg[g][pmc_pkg::B_ANEN] |-> ctl_out[g].full_duplex == ctrl_reg[g][pmc_pkg::B_DUPLEX];
            endproperty
            a_forced : assert property (p_forced)
                else $error("forced duplex ignored");

            property p_lpi;
                ctl_out[g].speed == pmc_pkg::SPD_10 |-> !ctl_out[g].lpi_allow;
            endproperty
            a_lpi : assert property (p_lpi)
                else $error("lpi at 10 mbps");

            property p_addr;
                straps_ok_reg && !ext1_reg[g][pmc_pkg::B_ADDR_REV] |->
                    ctl_out[g].mgmt_addr == ({straps_reg, 1'b0} + 5'(g));
            endproperty
            a_addr : assert property (p_addr)
                else $error("address wrong");
        end
    endgenerate

    // apb read mux
    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            prdata_reg <= 32'h0000_0000;
            perr_reg   <= 1'b0;
        end
        else if (psel_in && !penable_in)
        begin
            prdata_reg <= 32'h0000_0000;
            perr_reg   <= 1'b1;
            if (paddr_in == pmc_pkg::OFF_GLOBAL)
            begin
                prdata_reg[pmc_pkg::B_MACMODE +: 2] <= macmode_reg;
                perr_reg <= 1'b0;
            end
            for (int p = 0; p < NPORT; p++)
            begin
                if (hit(paddr_in, p, pmc_pkg::OFF_CTRL))
                begin
                    prdata_reg[15:0] <= ctrl_reg[p];
                    perr_reg <= 1'b0;
                end
                if (hit(paddr_in, p, pmc_pkg::OFF_STAT))
                begin
                    prdata_reg[pmc_pkg::B_UNICAP] <= 1'b1;
                    prdata_reg[pmc_pkg::B_LINKOK] <= line_in[p].link_ok;
                    perr_reg <= 1'b0;
                end
                if (hit(paddr_in, p, pmc_pkg::OFF_XOVCFG))
                begin
                    prdata_reg[15:0] <= xovcfg_reg[p];
                    perr_reg <= 1'b0;
                end
                if (hit(paddr_in, p, pmc_pkg::OFF_XOVSTAT))
                begin
                    prdata_reg[7:0] <= {2'h0, ctl_out[p].map, line_in[p].pol_inv};
                    perr_reg <= 1'b0;
                end
                if (hit(paddr_in, p, pmc_pkg::OFF_MANXOV))
                begin
                    prdata_reg[3:2] <= manxov_reg[p];
                    perr_reg <= 1'b0;
                end
                if (hit(paddr_in, p, pmc_pkg::OFF_EXT1))
                begin
                    prdata_reg[15:0] <= {ext1_reg[p][15:2], dsact_reg[p], ext1_reg[p][0]};
                    perr_reg <= 1'b0;
                end
                if (hit(paddr_in, p, pmc_pkg::OFF_EEE))
                begin
                    prdata_reg[pmc_pkg::B_TE] <= te_reg[p];
                    perr_reg <= 1'b0;
                end
                if (hit(paddr_in, p, pmc_pkg::OFF_SERAN))
                begin
                    prdata_reg[pmc_pkg::B_SERAN] <= seran_reg[p];
                    perr_reg <= 1'b0;
                end
                if (hit(paddr_in, p, pmc_pkg::OFF_ADDR))
                begin
                    prdata_reg[4:0] <= ctl_out[p].mgmt_addr;
                    perr_reg <= 1'b0;
                end
            end
        end
    end
endmodule : pmc_top
`default_nettype wire

/* rtl/pmc_pkg.sv */
// constants and carrier types of the media mode control block
package pmc_pkg;
    localparam int NPORT = 2;
    // register byte addresses, per port block of 0x40
    localparam logic [11:0] OFF_CTRL    = 12'h000;
    localparam logic [11:0] OFF_STAT    = 12'h004;
    localparam logic [11:0] OFF_XOVCFG  = 12'h008;
    localparam logic [11:0] OFF_XOVSTAT = 12'h00C;
    localparam logic [11:0] OFF_MANXOV  = 12'h010;
    localparam logic [11:0] OFF_EXT1    = 12'h014;
    localparam logic [11:0] OFF_EEE     = 12'h018;
    localparam logic [11:0] OFF_SERAN   = 12'h01C;
    localparam logic [11:0] OFF_ADDR    = 12'h020;
    localparam logic [11:0] OFF_GLOBAL  = 12'h100;
    localparam logic [11:0] PORT_STRIDE = 12'h040;
    // field positions
    localparam int B_SPD_LSB  = 6;
    localparam int B_UNIDIR   = 5;
    localparam int B_DUPLEX   = 8;
    localparam int B_ANEN     = 12;
    localparam int B_SPD_MSB  = 13;
    localparam int B_SWRST    = 15;
    localparam int B_LINKOK   = 2;
    localparam int B_UNICAP   = 7;
    localparam int B_XOV_DIS  = 5;
    localparam int B_POL_DIS  = 4;
    localparam int B_XOV_FORCED = 7;
    localparam int B_DS_EN    = 4;
    localparam int B_DS_CNT   = 2;
    localparam int B_DS_STAT  = 1;
    localparam int B_ADDR_REV = 9;
    localparam int B_TE       = 15;
    localparam int B_SERAN    = 7;
    localparam int B_MACMODE  = 14;
    // reset values
    localparam logic [15:0] CTRL_RST   = 16'h1140;
    localparam logic [15:0] XOVCFG_RST = 16'h0000;
    localparam logic [15:0] EXT1_RST   = 16'h0010;
    localparam logic [15:0] SERAN_RST  = 16'h0080;
    // mac modes
    localparam logic [1:0] MAC_SGMII  = 2'h0;
    localparam logic [1:0] MAC_QSGMII = 2'h1;
    // manual crossover codes
    localparam logic [1:0] MX_AUTO = 2'h0;
    localparam logic [1:0] MX_MDI  = 2'h2;
    localparam logic [1:0] MX_MDIX = 2'h3;
    // speed codes
    localparam logic [1:0] SPD_10   = 2'h0;
    localparam logic [1:0] SPD_100  = 2'h1;
    localparam logic [1:0] SPD_1000 = 2'h2;
    // wiring maps
    localparam logic [1:0] MAP_MDI     = 2'h0;
    localparam logic [1:0] MAP_MDIX    = 2'h1;
    localparam logic [1:0] MAP_MDI_CD  = 2'h2;
    localparam logic [1:0] MAP_MDIX_CD = 2'h3;

    typedef enum logic [2:0] {
        RR_LOCAL   = 3'b001,
        RR_WAIT    = 3'b010,
        RR_RECOVER = 3'b100
    } pmc_rr_e;

    // per-port view of the line side
    typedef struct packed {
        logic       link_ok;
        logic       partner_an;
        logic [1:0] pd_speed;
        logic       gig_fail;
        logic       gig_partner;
        logic [1:0] xov_map;
        logic [3:0] pol_inv;
        logic       ring_req;
        logic       timing_lock;
    } pmc_line_s;

    // per-port resolved controls
    typedef struct packed {
        logic       unidir_tx;
        logic       fibre_tx_en;
        logic       ams_en;
        logic       an_en;
        logic [1:0] speed;
        logic       full_duplex;
        logic       xov_auto;
        logic       pol_auto;
        logic [1:0] map;
        logic       adv_gig;
        logic       te_mode;
        logic       lpi_allow;
        logic       tx_recovered;
        logic [4:0] mgmt_addr;
        logic       soft_reset;
    } pmc_ctl_s;
endpackage : pmc_pkg

/* tb/pmc_partner.sv */
// link partner model driving the line side of both ports
`timescale 1ns/10ps
`default_nettype none
module pmc_partner #(
    parameter int LOCK_DLY = 5
) (
    // clock and reset
    input  wire logic                     clk_in,
    input  wire logic                     rst_in,
    // wanted line state and local gigabit advertisement
    input  wire pmc_pkg::pmc_line_s [1:0] want_in,
    input  wire logic [1:0]               adv_gig_in,
    // line side
    output pmc_pkg::pmc_line_s [1:0]      line_out
);
    int         lock_cnt [2];
    logic [1:0] tgl_reg;
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        for (int p = 0; p < 2; p++)
        begin
            if (rst_in)
            begin
                lock_cnt[p] <= 0;
                tgl_reg[p]  <= 1'b0;
            end
            else
            begin
                lock_cnt[p] <= want_in[p].ring_req ? lock_cnt[p] + 1 : 0;
                tgl_reg[p]  <= ~tgl_reg[p];
            end
        end
    end
    always_comb
    begin
        line_out = want_in;
        for (int p = 0; p < 2; p++)
        begin
            line_out[p].timing_lock = want_in[p].ring_req && (lock_cnt[p] >= LOCK_DLY);
            line_out[p].gig_fail = want_in[p].gig_fail && adv_gig_in[p] && tgl_reg[p];
        end
    end
endmodule : pmc_partner
`default_nettype wire

/* tb/phy_media_mode_control_test.sv */
// self-checking bench of the media mode control block
`timescale 1ns/10ps
`default_nettype none
module phy_media_mode_control_test;
    logic                     clk   = 1'b0;
    logic                     rst   = 1'b1;
    logic                     psel  = 1'b0;
    logic                     pen   = 1'b0;
    logic                     pwr   = 1'b0;
    logic [11:0]              paddr = 12'h000;
    logic [31:0]              pwd   = 32'h0;
    logic                     prdy;
    logic                     perr;
    logic                     er;
    logic [31:0]              prd;
    logic [31:0]              rd;
    logic [3:0]               strap;
    logic [4:0]               a5;
    logic [4:0]               a5r;
    pmc_pkg::pmc_line_s [1:0] want  = '0;
    pmc_pkg::pmc_line_s [1:0] line;
    pmc_pkg::pmc_ctl_s [1:0]  ctl;
    logic [1:0]               mmode;
    logic                     mquad;
    int                       err_count = 0;
    int                       n_checks  = 0;
    int                       fails     = 0;
    int                       f0;
    pmc_top pmc_top_inst (.core_clk_in(clk), .rst_in(rst), .psel_in(psel), .penable_in(pen),
        .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwd), .pready_out(prdy), .pslverr_out(perr),
        .prdata_out(prd), .board_address_straps_in(strap), .line_in(line), .ctl_out(ctl),
        .mac_mode_out(mmode), .mac_quad_out(mquad));
    pmc_partner pmc_partner_inst (.clk_in(clk), .rst_in(rst), .want_in(want),
        .adv_gig_in({ctl[1].adv_gig, ctl[0].adv_gig}), .line_out(line));
    always #2 clk = ~clk;
    always @(posedge clk) if (line[0].gig_fail === 1'b1) fails <= fails + 1;
    function automatic logic [11:0] ra(input int p, input logic [11:0] o);
        return 12'(p) * pmc_pkg::PORT_STRIDE + o;
    endfunction : ra
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel  <= 1'b1;
        pen   <= 1'b0;
        pwr   <= w;
        paddr <= a;
        pwd   <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (prdy !== 1'b1);
        rd = prd;
        er = perr;
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask : apb
    task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(nm, exp, rd);
    endtask : rchk
    task automatic wrap_up;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : wrap_up
    initial
    begin
        repeat (20000) @(posedge clk);
        err_count++;
        wrap_up();
    end
    initial
    begin
        void'($urandom(32'hC2C4));
        strap = 4'($urandom);
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        for (int p = 0; p < 2; p++)
        begin
            rchk("ctrl", ra(p, pmc_pkg::OFF_CTRL), 32'h1140); // autoneg on
            rchk("ext1", ra(p, pmc_pkg::OFF_EXT1), 32'h10); // downshift default
            rchk("seran", ra(p, pmc_pkg::OFF_SERAN), 32'h80); // default on
            rchk("stat", ra(p, pmc_pkg::OFF_STAT), 32'h80); // capability bit
            a5 = {strap, 1'b0} + 5'(p);
            rchk("addr", ra(p, pmc_pkg::OFF_ADDR), 32'(a5)); // strap address
            chk("xov_auto", 1, ctl[p].xov_auto); // default on
            chk("pol_auto", 1, ctl[p].pol_auto); // default on
        end
        apb(1'b0, 12'h024, 32'h0);
        chk("unmapped data", 0, rd);
        chk("unmapped err", 1, er);
        apb(1'b1, ra(0, pmc_pkg::OFF_EXT1), 32'h0210);
        a5  = {strap, 1'b0};
        a5r = {<<{a5}};
        rchk("addr rev", ra(0, pmc_pkg::OFF_ADDR), 32'(a5r)); // reversal
        chk("addr p1", 32'({strap, 1'b0} + 5'h01), ctl[1].mgmt_addr); // per port
        for (int m = 0; m < 4; m++)
        begin
            apb(1'b1, pmc_pkg::OFF_GLOBAL, 32'(m) << 14);
            @(negedge clk);
            chk("mac_mode", m, mmode); // mode field
            chk("mac_quad", m == 1, mquad); // mode field
        end
        want[0].link_ok <= 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b1, ra(0, pmc_pkg::OFF_CTRL), (32'(i / 2) << 6) | (32'(i % 2) * 32'h2100));
            @(negedge clk);
            chk("speed", (i == 0) ? 0 : (i == 1) ? 1 : 2, ctl[0].speed); // forced
            chk("duplex", i % 2, ctl[0].full_duplex); // forced
            chk("an_en", 0, ctl[0].an_en); // autoneg off
            chk("lpi", i != 0, ctl[0].lpi_allow); // lpi speeds
        end
        apb(1'b1, ra(0, pmc_pkg::OFF_CTRL), 32'h1140);
        want[0].pd_speed <= pmc_pkg::SPD_100;
        @(negedge clk);
        chk("pd speed", pmc_pkg::SPD_100, ctl[0].speed); // parallel detect
        @(posedge clk);
        want[0].link_ok <= 1'b0;
        apb(1'b1, ra(0, pmc_pkg::OFF_SERAN), 32'h0); // serial autoneg off
        rchk("seran", ra(0, pmc_pkg::OFF_SERAN), 32'h0); // readback
        apb(1'b1, ra(0, pmc_pkg::OFF_CTRL), 32'h20); // fixed fibre mode
        @(negedge clk);
        chk("unidir", 1, ctl[0].unidir_tx); // enable
        chk("fibre tx", 1, ctl[0].fibre_tx_en); // no link needed
        chk("ams", 0, ctl[0].ams_en); // sensing off
        chk("unidir p1", 0, ctl[1].unidir_tx); // per port
        rchk("stat", ra(0, pmc_pkg::OFF_STAT), 32'h80); // capability bit
        want[0].xov_map <= pmc_pkg::MAP_MDIX_CD;
        apb(1'b1, ra(0, pmc_pkg::OFF_MANXOV), 32'h8);
        @(negedge clk);
        chk("map", pmc_pkg::MAP_MDI, ctl[0].map); // force straight
        apb(1'b1, ra(0, pmc_pkg::OFF_MANXOV), 32'hC);
        @(negedge clk);
        chk("map", pmc_pkg::MAP_MDIX, ctl[0].map); // force crossed
        apb(1'b1, ra(0, pmc_pkg::OFF_MANXOV), 32'h0);
        for (int m = 0; m < 4; m++)
        begin
            @(posedge clk);
            want[0].xov_map <= 2'(m);
            @(negedge clk);
            chk("map", m, ctl[0].map); // auto maps
        end
        chk("xov forced", 1, ctl[0].xov_auto); // bit 7 clear
        rchk("xovstat", ra(0, pmc_pkg::OFF_XOVSTAT), 32'h30); // status
        apb(1'b1, ra(0, pmc_pkg::OFF_XOVCFG), 32'h80);
        @(negedge clk);
        chk("xov forced", 0, ctl[0].xov_auto); // bit 7 set
        apb(1'b1, ra(0, pmc_pkg::OFF_XOVCFG), 32'h30);
        @(negedge clk);
        chk("xov_auto", 0, ctl[0].xov_auto); // adjustable
        chk("pol_auto", 0, ctl[0].pol_auto); // adjustable
        apb(1'b1, ra(0, pmc_pkg::OFF_CTRL), 32'h1140);
        apb(1'b1, ra(0, pmc_pkg::OFF_EXT1), 32'h18);
        f0 = fails;
        want[0].gig_fail   <= 1'b1;
        want[0].partner_an <= 1'b1;
        for (int k = 0; k < 60 && ctl[0].adv_gig !== 1'b0; k++) @(negedge clk);
        chk("fail count", 3, fails - f0); // count plus one
        chk("ds speed", pmc_pkg::SPD_100, ctl[0].speed); // next slower
        rchk("ext1 stat", ra(0, pmc_pkg::OFF_EXT1), 32'h1A); // status bit
        want[0].gig_fail    <= 1'b0;
        want[0].gig_partner <= 1'b1;
        @(posedge clk);
        @(negedge clk);
        chk("adv_gig", 1, ctl[0].adv_gig); // no reset
        apb(1'b1, ra(1, pmc_pkg::OFF_EEE), 32'h8000);
        @(negedge clk);
        chk("te p1", 1, ctl[1].te_mode); // own bit
        chk("te p0", 0, ctl[0].te_mode); // per port
        @(posedge clk);
        want[0].ring_req <= 1'b1;
        for (int k = 0; k < 12 && line[0].timing_lock !== 1'b1; k++)
        begin
            @(negedge clk);
            if (line[0].timing_lock !== 1'b1) chk("recovered early", 0, ctl[0].tx_recovered);
        end
        for (int k = 0; k < 4 && ctl[0].tx_recovered !== 1'b1; k++) @(negedge clk);
        chk("recovered", 1, ctl[0].tx_recovered); // after lock
        apb(1'b1, ra(0, pmc_pkg::OFF_CTRL), 32'h9140);
        @(negedge clk);
        chk("swrst", 1, ctl[0].soft_reset); // reset pulse
        rchk("ctrl swrst", ra(0, pmc_pkg::OFF_CTRL), 32'h1140); // self clear
        wrap_up();
    end
endmodule : phy_media_mode_control_test
`default_nettype wire
